// [core/tx_payload_and_line_pins.sv]
// transmit payload input pins, message byte input and line rail outputs of one channel
// Contract
// (R1) The shared pin feeds nibble bit 2 or message byte bit 2, per HDLC mode.
// (R2) Terminal equipment presents outbound payload on the nibble input pins.
// (R3) In nibble mode, nibble pins are sampled on each rising nibble clock edge.
// (R4) Nibble pins are used only in nibble-parallel payload mode, ignored otherwise; the code also reads them as message byte bits whenever HDLC mode is set.
// (R5) In HDLC mode the shared pin is bit 2 of the message byte input.
// (R6) Single-rail: negative rail high for one bit period at each frame end only.
// (R7) Dual-rail: negative rail carries the negative pulses beside the positive rail.
// (R8) Rail mode and HDLC mode are software configuration bits set before traffic.
module tx_payload_and_line_pins (
    input wire logic sys_clk, // 125 MHz system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [3:0] reg_addr, // register byte address
    input wire logic [31:0] reg_wdata, // register write data
    input wire logic reg_wr, // register write strobe
    input wire logic reg_rd, // register read strobe
    output logic [31:0] reg_rdata, // read data, cycle after the strobe
    input wire logic tx_nibble_clock, // nibble clock pin from the terminal
    input wire logic tx_payload_nibble_bit2, // shared pin: nibble bit 2 or byte bit 2
    input wire logic [2:0] tx_nibble_other, // nibble bits 3, 1 and 0, shared with byte bits
    input wire logic [3:0] tx_message_upper, // message byte bits 7 to 4
    output logic tx_positive_rail, // positive rail or data to the line unit
    output logic tx_negative_rail // frame end mark or negative pulses
);
    // ******************************************************************
    // state
    // ******************************************************************
    typedef enum logic {
        LINE_IDLE,
        LINE_RUN
    } line_state_type;

    typedef struct packed {
        logic [tx_line_pkg::PIN_WIDTH-1:0] sync1;
        logic [tx_line_pkg::PIN_WIDTH-1:0] sync2;
        logic [tx_line_pkg::PIN_WIDTH-1:0] sync3;
        logic [tx_line_pkg::PIN_WIDTH-1:0] filt;
        logic [tx_line_pkg::CTRL_WIDTH-1:0] ctrl;
        logic [31:0] rdata;
        logic overflow;
        logic [15:0] frames;
        logic [3:0] nib_hi;
        logic nib_half;
        logic push;
        logic [7:0] push_data;
        line_state_type line;
        logic [3:0] div;
        logic [10:0] bit_cnt;
        logic [7:0] shift;
        logic [2:0] bits_left;
        logic neg_next;
        logic pos;
        logic neg;
    } main_state_type;

    main_state_type st_q;
    main_state_type st_d;
    logic [tx_line_pkg::PIN_WIDTH-1:0] pins;
    logic [tx_line_pkg::PIN_WIDTH-1:0] agree;
    logic [tx_line_pkg::PIN_WIDTH-1:0] filt_new;
    logic clk_rise;
    logic [7:0] byte_in;
    logic [3:0] nibble_in;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic fifo_pop;
    logic [tx_line_pkg::LEVEL_WIDTH-1:0] fifo_level;
    logic dual_rail;
    logic hdlc_mode;
    logic nibble_mode;
    logic bit_tick;
    logic frame_last;

    // ******************************************************************
    // pin filtering and input routing
    // ******************************************************************
    // a pin change counts only once the second and third stage agree
    assign pins = {tx_nibble_clock, tx_message_upper, tx_nibble_other[2], tx_payload_nibble_bit2,
                   tx_nibble_other[1:0]};
    // stage one may still be settling, so only stages two and three are compared
    // the filter costs about four cycles: data must stand that long past the clock edge
    assign agree = ~(st_q.sync2 ^ st_q.sync3);
    assign filt_new = (agree & st_q.sync3) | (~agree & st_q.filt);
    assign clk_rise = filt_new[tx_line_pkg::PIN_CLOCK_BIT] && !st_q.filt[tx_line_pkg::PIN_CLOCK_BIT];
    assign byte_in = filt_new[7:0]; // shared pin lands on byte bit 2 [R5]
    assign nibble_in = filt_new[3:0]; // shared pin lands on nibble bit 2 [R1]

    // configuration decode
    assign dual_rail = st_q.ctrl[tx_line_pkg::CTRL_DUAL_RAIL_BIT];
    assign hdlc_mode = st_q.ctrl[tx_line_pkg::CTRL_HDLC_BIT];
    assign nibble_mode = st_q.ctrl[tx_line_pkg::CTRL_MODE_LSB +: 2] == tx_line_pkg::MODE_NIBBLE;

    // line timing strobes
    assign bit_tick = (st_q.line == LINE_RUN) && (st_q.div == tx_line_pkg::BIT_CYCLES - 4'h1);
    // the mark rides on the last bit, so the frame count and the mark move together
    assign frame_last = st_q.bit_cnt == tx_line_pkg::FRAME_BITS - 11'h001;
    // the line only pulls a byte when one is due, so the fifo really fills
    assign fifo_pop = bit_tick && (st_q.bits_left == 3'h0) && fifo_out_valid;

    // ******************************************************************
    // buffer between the terminal side and the line side
    // ******************************************************************
    // sixteen bytes absorb the uneven terminal clock against the steady line rate
    byte_fifo #(
        .WIDTH(tx_line_pkg::FIFO_WIDTH),
        .DEPTH(tx_line_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(st_q.push),
        .in_data(st_q.push_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_pop),
        .level(fifo_level)
    );

    // ******************************************************************
    // next state
    // ******************************************************************
    always_comb
    begin
        logic [7:0] cur;
        logic line_bit;
        cur = 8'h00;
        line_bit = 1'b0;
        st_d = st_q;
        st_d.sync1 = pins;
        st_d.sync2 = st_q.sync1;
        st_d.sync3 = st_q.sync2;
        st_d.filt = filt_new;
        st_d.push = 1'b0;
        // a full fifo refuses the word; the drop is flagged, set beating clear
        if (st_q.push && !fifo_in_ready)
        begin
            st_d.overflow = 1'b1;
        end
        // register writes; configuration is expected before traffic starts
        if (reg_wr && reg_addr == tx_line_pkg::CTRL_ADDR)
        begin
            st_d.ctrl = reg_wdata[tx_line_pkg::CTRL_WIDTH-1:0]; // [R8]
            st_d.nib_half = 1'b0;
        end
        if (reg_wr && reg_addr == tx_line_pkg::STATUS_ADDR && reg_wdata[tx_line_pkg::STAT_OVERFLOW_CLR_BIT]
            && !(st_q.push && !fifo_in_ready))
        begin
            st_d.overflow = 1'b0;
        end
        // register reads answer in the next cycle, unmapped reads give zero
        st_d.rdata = 32'h0000_0000;
        if (reg_rd && reg_addr == tx_line_pkg::CTRL_ADDR)
        begin
            st_d.rdata[tx_line_pkg::CTRL_WIDTH-1:0] = st_q.ctrl;
        end
        else if (reg_rd && reg_addr == tx_line_pkg::STATUS_ADDR)
        begin
            st_d.rdata[tx_line_pkg::STAT_FRAMES_LSB +: 16] = st_q.frames;
            st_d.rdata[tx_line_pkg::STAT_LEVEL_LSB +: tx_line_pkg::LEVEL_WIDTH] = fifo_level;
            st_d.rdata[tx_line_pkg::STAT_OVERFLOW_BIT] = st_q.overflow;
        end
        // terminal side capture on the nibble clock rising edge
        if (clk_rise && hdlc_mode)
        begin
            st_d.push = 1'b1; // whole message byte per edge [R5] [R1]
            st_d.push_data = byte_in;
        end
        else if (clk_rise && nibble_mode) // hdlc mode has priority [R4]
        begin
            // upper nibble first, the pair forms one byte [R3]
            if (st_q.nib_half)
            begin
                st_d.push = 1'b1;
                st_d.push_data = {st_q.nib_hi, nibble_in};
                st_d.nib_half = 1'b0;
            end
            else
            begin
                st_d.nib_hi = nibble_in;
                st_d.nib_half = 1'b1;
            end
        end
        // other payload modes leave the nibble pins unread unless hdlc mode is set [R4]
        // line side: bit divider and frame counter
        unique case (st_q.line)
            LINE_IDLE:
            begin
                st_d.pos = 1'b0;
                st_d.neg = 1'b0;
                st_d.div = 4'h0;
                st_d.bit_cnt = 11'h000;
                st_d.bits_left = 3'h0;
                if (st_q.ctrl[tx_line_pkg::CTRL_ENABLE_BIT])
                begin
                    st_d.line = LINE_RUN;
                end
            end
            LINE_RUN:
            begin
                st_d.div = bit_tick ? 4'h0 : st_q.div + 4'h1;
                if (bit_tick)
                begin
                    // an empty fifo sends a zero byte rather than stalling the line
                    if (st_q.bits_left == 3'h0)
                    begin
                        cur = fifo_out_valid ? fifo_out_data : 8'h00;
                        st_d.bits_left = 3'h7;
                    end
                    else
                    begin
                        cur = st_q.shift;
                        st_d.bits_left = st_q.bits_left - 3'h1;
                    end
                    line_bit = cur[7];
                    st_d.shift = {cur[6:0], 1'b0};
                    st_d.bit_cnt = frame_last ? 11'h000 : st_q.bit_cnt + 11'h001;
                    if (frame_last)
                    begin
                        st_d.frames = st_q.frames + 16'h0001;
                    end
                    if (dual_rail)
                    begin
                        // polarity memory survives idle, so alternation carries across bytes
                        // marks alternate polarity; never both rails at once [R7]
                        st_d.pos = line_bit && !st_q.neg_next;
                        st_d.neg = line_bit && st_q.neg_next;
                        if (line_bit)
                        begin
                            st_d.neg_next = !st_q.neg_next;
                        end
                    end
                    else
                    begin
                        st_d.pos = line_bit;
                        st_d.neg = frame_last; // one bit period at frame end [R6]
                    end
                end
                if (!st_q.ctrl[tx_line_pkg::CTRL_ENABLE_BIT])
                begin
                    st_d.line = LINE_IDLE;
                end
            end
        endcase
    end

    // ******************************************************************
    // registers
    // ******************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q <= '0;
            st_q.ctrl <= tx_line_pkg::CTRL_RESET;
            st_q.line <= LINE_IDLE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // every output comes straight from the state register
    assign reg_rdata = st_q.rdata;
    assign tx_positive_rail = st_q.pos;
    assign tx_negative_rail = st_q.neg;

    // ******************************************************************
    // checks
    // ******************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // checks follow the mode seen at the sampling edge; a mid-frame mode change is outside the contract

    sequence s_byte_edge;
        clk_rise && hdlc_mode;
    endsequence

    sequence s_second_nibble;
        clk_rise && !hdlc_mode && nibble_mode && st_q.nib_half;
    endsequence

    sequence s_first_nibble;
        clk_rise && !hdlc_mode && nibble_mode && !st_q.nib_half;
    endsequence

    sequence s_frame_end_tick;
        bit_tick && frame_last && !dual_rail;
    endsequence

    a_hdlc_byte_bit2: assert property (s_byte_edge |=> st_q.push && st_q.push_data[2] == $past(filt_new[2])) // [R5]
        else $error("message byte bit 2 not taken from shared pin");

    a_nibble_bit2_route: assert property (s_second_nibble // [R1]
        |=> st_q.push && st_q.push_data[2] == $past(filt_new[2]) && st_q.push_data[6] == st_q.nib_hi[2])
        else $error("nibble bit 2 not taken from shared pin");

    a_nibble_pair_push: assert property (s_second_nibble |=> st_q.push && !st_q.nib_half) // [R3]
        else $error("nibble pair did not form a byte");

    a_other_mode_ignored: assert property (!hdlc_mode && !nibble_mode && !reg_wr // [R4]
        |=> !st_q.push && st_q.nib_half == $past(st_q.nib_half))
        else $error("nibble pins used outside nibble mode");

    a_single_rail_end: assert property (s_frame_end_tick // [R6]
        |=> tx_negative_rail ##1 tx_negative_rail [*3] ##1 !tx_negative_rail)
        else $error("frame end mark not one bit period");

    a_single_rail_quiet: assert property (bit_tick && !frame_last && !dual_rail |=> !tx_negative_rail) // [R6]
        else $error("negative rail high outside frame end");

    a_dual_rail_excl: assert property (dual_rail && bit_tick && st_q.bits_left != 3'h0 // [R7]
        |=> tx_negative_rail == ($past(st_q.shift[7]) && $past(st_q.neg_next))
        && !(tx_negative_rail && tx_positive_rail))
        else $error("negative pulse wrong in dual rail");

    a_ctrl_write_load: assert property (reg_wr && reg_addr == tx_line_pkg::CTRL_ADDR // [R8]
        |=> st_q.ctrl == $past(reg_wdata[tx_line_pkg::CTRL_WIDTH-1:0]))
        else $error("configuration write not stored");

    a_first_nibble_hold: assert property (s_first_nibble // [R3]
        |=> st_q.nib_half && !st_q.push && st_q.nib_hi == $past(nibble_in))
        else $error("first nibble not held");

    a_hdlc_whole_byte: assert property (s_byte_edge |=> st_q.push_data == $past(byte_in)) // [R5]
        else $error("message byte not taken whole");

    a_push_needs_edge: assert property (!clk_rise |=> !st_q.push) // [R3]
        else $error("byte pushed without a clock edge");

    a_single_rail_data: assert property (!dual_rail && bit_tick && st_q.bits_left != 3'h0 // [R6]
        |=> tx_positive_rail == $past(st_q.shift[7]))
        else $error("payload bit not on positive rail");

    a_dual_byte_start: assert property (dual_rail && bit_tick && st_q.bits_left == 3'h0 // [R7]
        |=> tx_negative_rail == ($past(fifo_out_valid) && $past(fifo_out_data[7]) && $past(st_q.neg_next)))
        else $error("negative pulse wrong at byte start");

    a_dual_never_both: assert property (dual_rail && bit_tick |=> !(tx_negative_rail && tx_positive_rail)) // [R7]
        else $error("both rails high in dual rail");

    a_idle_rails_low: assert property (st_q.line == LINE_IDLE |=> !tx_negative_rail && !tx_positive_rail) // [R6]
        else $error("rails not low while the line is off");

    a_frame_count: assert property (bit_tick && frame_last |=> st_q.frames == $past(st_q.frames) + 16'h0001) // [R6]
        else $error("frame count not advanced at frame end");

    a_ctrl_held: assert property (!reg_wr |=> st_q.ctrl == $past(st_q.ctrl)) // [R8]
        else $error("configuration changed without a write");
endmodule

// [core/tx_line_pkg.sv]
// constants shared by the transmit payload and line pin block
package tx_line_pkg;
    // register offsets on the plain register port
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    // control register field positions
    localparam int CTRL_DUAL_RAIL_BIT = 0;
    localparam int CTRL_HDLC_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_ENABLE_BIT = 4;
    localparam int CTRL_WIDTH = 5;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // payload mode codes in the control mode field
    localparam logic [1:0] MODE_SERIAL = 2'h0;
    localparam logic [1:0] MODE_NIBBLE = 2'h1;
    // status register field positions
    localparam int STAT_FRAMES_LSB = 0;
    localparam int STAT_LEVEL_LSB = 16;
    localparam int STAT_OVERFLOW_BIT = 24;
    localparam int STAT_OVERFLOW_CLR_BIT = 24;
    // buffer shape
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int LEVEL_WIDTH = 5;
    // line timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int BIT_PERIOD_NS = 32;
    localparam logic [3:0] BIT_CYCLES = 4'((BIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [10:0] FRAME_BITS = 11'h600;
    // pin bus: bit 8 is the nibble clock, bits 7:0 the shared data pins
    localparam int PIN_CLOCK_BIT = 8;
    localparam int PIN_WIDTH = 9;
endpackage

// [core/byte_fifo.sv]
// flip-flop fifo with valid and ready on both sides
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic in_valid, // write request
    input wire logic [WIDTH-1:0] in_data, // write word
    output logic in_ready, // room for a word
    output logic out_valid, // a word is waiting
    output logic [WIDTH-1:0] out_data, // oldest word
    input wire logic out_ready, // reader takes the word
    output logic [$clog2(DEPTH+1)-1:0] level // words held
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } fifo_state_type;

    fifo_state_type st_q;
    fifo_state_type st_d;
    logic do_push;
    logic do_pop;

    // flags come from the count so full and empty are never stale
    assign in_ready = st_q.count != CW'(DEPTH);
    assign out_valid = st_q.count != '0;
    assign out_data = st_q.mem[st_q.rd_ptr];
    assign level = st_q.count;
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    // next state: write, read and count update
    always_comb
    begin
        st_d = st_q;
        if (do_push)
        begin
            st_d.mem[st_q.wr_ptr] = in_data;
            st_d.wr_ptr = (st_q.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_q.wr_ptr + 1'b1;
        end
        if (do_pop)
        begin
            st_d.rd_ptr = (st_q.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_q.rd_ptr + 1'b1;
        end
        if (do_push && !do_pop)
        begin
            st_d.count = st_q.count + 1'b1;
        end
        else if (do_pop && !do_push)
        begin
            st_d.count = st_q.count - 1'b1;
        end
    end

    // storage is left out of reset, only pointers and count clear
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q.mem <= st_d.mem;
            st_q.wr_ptr <= '0;
            st_q.rd_ptr <= '0;
            st_q.count <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end
endmodule

// [verification/terminal_model.sv]
// terminal equipment model driving the nibble clock and the shared data pins
module terminal_model (
    input wire logic sys_clk, // system clock
    output logic nib_clk, // nibble clock pin
    output logic bit2, // shared bit 2 pin
    output logic [2:0] other, // nibble bits 3, 1 and 0
    output logic [3:0] upper // message byte bits 7 to 4
);
    timeunit 1ns;
    timeprecision 1ps;

    // pins start low; the clock stands still until a word is sent
    initial
    begin
        nib_clk = 1'b0;
        bit2 = 1'b0;
        other = 3'h0;
        upper = 4'h0;
    end

    // one rising clock edge with a word on the pins; data is held well past the filter delay, then
    // the pins turn to the inverse so that a late sample can never look correct
    task automatic send_edge(input logic [7:0] word);
        @(posedge sys_clk);
        upper <= word[7:4];
        other <= {word[3], word[1:0]};
        bit2 <= word[2];
        repeat (2) @(posedge sys_clk);
        nib_clk <= 1'b1;
        repeat (6) @(posedge sys_clk);
        nib_clk <= 1'b0;
        repeat (4) @(posedge sys_clk);
        upper <= ~word[7:4];
        other <= ~{word[3], word[1:0]};
        bit2 <= ~word[2];
    endtask
endmodule

// [verification/test_tx_payload_and_line_pins.sv]
// self-checking testbench for the transmit payload and line pin block
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

module test_tx_payload_and_line_pins;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk;
    logic rst;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic nib_clk;
    logic bit2;
    logic [2:0] other;
    logic [3:0] upper;
    logic pos_rail;
    logic neg_rail;
    logic [31:0] rd_val;
    int error_cnt = 0;
    int n_compared = 0;

    // ************************************************
    // clock, design and terminal model
    // ************************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    tx_payload_and_line_pins dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_nibble_clock(nib_clk),
        .tx_payload_nibble_bit2(bit2), .tx_nibble_other(other), .tx_message_upper(upper),
        .tx_positive_rail(pos_rail), .tx_negative_rail(neg_rail));

    terminal_model term (.sys_clk(sys_clk), .nib_clk(nib_clk), .bit2(bit2), .other(other), .upper(upper));

    // ************************************************
    // bus and helper tasks
    // ************************************************
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // filtered pins need a few cycles after release before the first clock edge
    task automatic reset_dut();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask

    // called right after the enabling write; samples each bit one cycle into its four-cycle period
    task automatic check_line(input logic [7:0] b, input logic dual);
        logic ph;
        ph = 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
        for (int i = 7; i >= 0; i--)
        begin
            if (dual)
            begin
                `CHK(pos_rail, b[i] & ~ph)
                `CHK(neg_rail, b[i] & ph)
                ph = ph ^ b[i];
            end
            else
            begin
                `CHK(pos_rail, b[i])
                `CHK(neg_rail, 1'b0)
            end
            repeat (4) @(posedge sys_clk);
            #1;
        end
    endtask

    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_registers();
        reset_dut();
        `CHK({pos_rail, neg_rail}, 2'h0)
        rd(tx_line_pkg::CTRL_ADDR, rd_val);
        `CHK(rd_val, 32'h0000_0000)
        rd(tx_line_pkg::STATUS_ADDR, rd_val);
        `CHK(rd_val, 32'h0000_0000)
        wr(4'h8, 32'hFFFF_FFFF);
        rd(4'h8, rd_val);
        `CHK(rd_val, 32'h0000_0000)
        wr(tx_line_pkg::CTRL_ADDR, 32'hFFFF_FFEF);
        rd(tx_line_pkg::CTRL_ADDR, rd_val);
        `CHK(rd_val, 32'h0000_000F)
        $display("test registers done");
    endtask

    task automatic t_nibble_single();
        reset_dut();
        wr(tx_line_pkg::CTRL_ADDR, 32'h0000_0004);
        term.send_edge(8'h0A);
        term.send_edge(8'h05);
        rd(tx_line_pkg::STATUS_ADDR, rd_val);
        `CHK(rd_val[20:16], 5'h01)
        wr(tx_line_pkg::CTRL_ADDR, 32'h0000_0014);
        check_line(8'hA5, 1'b0);
        $display("test nibble single rail done");
    endtask

    // serial and unused modes must leave the pins unused
    task automatic t_ignore_modes();
        reset_dut();
        for (int m = 0; m < 4; m++)
        begin
            if (m != 1)
            begin
                wr(tx_line_pkg::CTRL_ADDR, 32'(m) << 2);
                term.send_edge(8'h0C);
                term.send_edge(8'h03);
                rd(tx_line_pkg::STATUS_ADDR, rd_val);
                `CHK(rd_val[20:16], 5'h00)
            end
        end
        $display("test ignored modes done");
    endtask

    task automatic t_hdlc();
        reset_dut();
        wr(tx_line_pkg::CTRL_ADDR, 32'h0000_0002);
        term.send_edge(8'h5E);
        rd(tx_line_pkg::STATUS_ADDR, rd_val);
        `CHK(rd_val[20:16], 5'h01)
        wr(tx_line_pkg::CTRL_ADDR, 32'h0000_0012);
        check_line(8'h5E, 1'b0);
        $display("test message byte done");
    endtask

    task automatic t_dual();
        reset_dut();
        wr(tx_line_pkg::CTRL_ADDR, 32'h0000_0005);
        term.send_edge(8'h0B);
        term.send_edge(8'h07);
        wr(tx_line_pkg::CTRL_ADDR, 32'h0000_0015);
        check_line(8'hB7, 1'b1);
        $display("test dual rail done");
    endtask

    // the frame end mark comes on bit 1535 after enable and lasts one bit period
    task automatic t_frame_end();
        int k;
        int h;
        reset_dut();
        wr(tx_line_pkg::CTRL_ADDR, 32'h0000_0010);
        k = 0;
        h = 0;
        while (neg_rail !== 1'b1 && k < 7000)
        begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        `CHK(k >= 6144 && k <= 6146, 1'b1)
        while (neg_rail === 1'b1 && h < 10)
        begin
            @(posedge sys_clk);
            #1;
            h++;
        end
        `CHK(h, 4)
        rd(tx_line_pkg::STATUS_ADDR, rd_val);
        `CHK(rd_val[15:0], 16'h0001)
        $display("test frame end done");
    endtask

    // fill the buffer past full with the line off, clear the sticky flag, then drain it
    task automatic t_fifo_full();
        int n;
        reset_dut();
        wr(tx_line_pkg::CTRL_ADDR, 32'h0000_0002);
        for (int i = 0; i < 17; i++)
            term.send_edge(8'(i));
        rd(tx_line_pkg::STATUS_ADDR, rd_val);
        `CHK(rd_val[24:16], 9'h110)
        wr(tx_line_pkg::STATUS_ADDR, 32'h0100_0000);
        rd(tx_line_pkg::STATUS_ADDR, rd_val);
        `CHK(rd_val[24:16], 9'h010)
        wr(tx_line_pkg::CTRL_ADDR, 32'h0000_0012);
        n = 0;
        do
        begin
            repeat (32) @(posedge sys_clk);
            rd(tx_line_pkg::STATUS_ADDR, rd_val);
            n++;
        end
        while (rd_val[20:16] !== 5'h00 && n < 30);
        `CHK(rd_val[20:16], 5'h00)
        $display("test buffer fill and drain done");
    endtask

    // ************************************************
    // main sequence
    // ************************************************
    initial
    begin
        // every bus input is driven from here, with reset held from time zero
        rst <= 1'b1;
        reg_addr <= 4'h0;
        reg_wdata <= 32'h0000_0000;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        t_registers();
        t_nibble_single();
        t_ignore_modes();
        t_hdlc();
        t_dual();
        t_frame_end();
        t_fifo_full();
        report_and_stop();
    end

    // guard against a hang anywhere in the sequence
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        error_cnt++;
        report_and_stop();
    end
endmodule
